/* File: core/fm_blend_params.svh */
// Constants of the FM stereo blend audio back end
`ifndef FM_BLEND_PARAMS_SVH
`define FM_BLEND_PARAMS_SVH
`define DEEMPH_SEL_50US 2'h1
`define DEEMPH_SEL_75US 2'h2
`define DEEMPH_TC_50_US 50
`define DEEMPH_TC_75_US 75
`define SAMPLE_RATE_HZ 48000
`define DEEMPH_K_50 16'h0a9b
`define DEEMPH_K_75 16'h0727
`define BLEND_FULL 8'hff
`define BLEND_ZERO 8'h00
`define PILOT_LOCK_THR 16'h0400
`endif

/* File: core/fm_blend_pkg.sv */
// Types shared by the FM stereo blend audio back end
package fm_blend_pkg;
	typedef struct packed {
		logic [7:0] rssi;
		logic [7:0] snr;
		logic [7:0] multipath;
	} quality_t;
	typedef struct packed {
		logic [7:0] stereoThr;
		logic [7:0] monoThr;
		logic [7:0] attack;
		logic [7:0] relRate;
	} blend_cfg_t;
	typedef struct packed {
		logic [15:0] left;
		logic [15:0] right;
	} stereo_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_MATRIX = 2'b01,
		ST_FILTER = 2'b11,
		ST_OUTPUT = 2'b10
	} proc_state_t;
endpackage : fm_blend_pkg

/* File: core/metric_blend.sv */
// Blend target of one quality metric between its mono and stereo thresholds
`timescale 1ns/100ps
module metric_blend
	import fm_blend_pkg::*;
(
	input wire logic [7:0] metric,
	input wire blend_cfg_t cfg,
	output logic [7:0] monoAmount
);
	logic [15:0] num;
	logic [7:0] span;
	always_comb begin
		span = cfg.stereoThr - cfg.monoThr;
		num = 16'h0000;
		if (metric < cfg.monoThr || cfg.monoThr >= cfg.stereoThr) begin
			monoAmount = 8'hff;
		end else if (metric > cfg.stereoThr) begin
			monoAmount = 8'h00;
		end else begin
			num = {8'h00, cfg.stereoThr - metric} * 16'h00ff;
			monoAmount = 8'(num / {8'h00, span});
		end
	end
endmodule : metric_blend

/* File: core/fm_stereo_blend_audio_dsp.sv */
// FM stereo decoder, blend, de-emphasis, soft mute and volume back end
// Operation
// - Left is sum plus difference; right is sum minus difference.
// - Band-limited sum signal serves as the mono audio output.
// - Difference signal recovered by demodulating with the pilot reference.
// - Three metrics watched together; poorest one sets the blend.
// - Any metric below its mono threshold forces full mono.
// - All metrics above stereo thresholds give no blending.
// - Between thresholds blend proportionally, approached at set rates.
// - Each metric has own stereo and mono thresholds and rates.
// - Blend state reported on the signal quality status command.
// - Measured metrics are reported to the host.
// - De-emphasis filter of 50 or 75 microseconds.
// - Setting 2 selects 75 us, setting 1 selects 50 us.
// - Host can mute the analog outputs.
// - Output level scaled digitally by the volume setting.
// - Soft mute engages when SNR falls below its threshold.
// - Soft mute amount and attack and decay rates programmable.
`timescale 1ns/100ps
`include "fm_blend_params.svh"
module fm_stereo_blend_audio_dsp
	import fm_blend_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic sampleValid,
	input wire logic [15:0] sumIn,
	input wire logic [15:0] diffMpxIn,
	input wire logic [15:0] pilotRef,
	input wire quality_t qualityIn,
	input wire blend_cfg_t rssiCfg,
	input wire blend_cfg_t snrCfg,
	input wire blend_cfg_t mpathCfg,
	input wire logic [1:0] deemph_time_const_setting,
	input wire logic muteReq,
	input wire logic [7:0] volume,
	input wire logic [7:0] softMuteThr,
	input wire logic [7:0] softMuteMax,
	input wire logic [7:0] softMuteAttack,
	input wire logic [7:0] softMuteDecay,
	input wire logic signal_quality_status_cmd,
	output stereo_t audioOut,
	output logic [15:0] left_analog_out,
	output logic [15:0] right_analog_out,
	output logic audioValid,
	output logic statusValid,
	output logic [7:0] blendStatus,
	output logic stereoStatus,
	output quality_t qualityStatus,
	output logic [7:0] softMuteStatus
);
	// ==============================
	// Helpers
	function automatic logic [7:0] step_toward(input logic [7:0] cur,
		input logic [7:0] tgt, input logic [7:0] up, input logic [7:0] dn);
		logic [8:0] s;
		s = 9'h000;
		if (tgt > cur) begin
			s = {1'b0, cur} + {1'b0, (up == 8'h00) ? 8'h01 : up};
			step_toward = (s[8] || s[7:0] > tgt) ? tgt : s[7:0];
		end else if (tgt < cur) begin
			s = {1'b0, cur} - {1'b0, (dn == 8'h00) ? 8'h01 : dn};
			step_toward = (s[8] || s[7:0] < tgt) ? tgt : s[7:0];
		end else begin
			step_toward = cur;
		end
	endfunction : step_toward
	function automatic logic [15:0] scale(input logic [15:0] x,
		input logic [7:0] g);
		logic [23:0] p;
		p = 24'($signed(x)) * 24'($signed({1'b0, g}));
		scale = p[23:8];
	endfunction : scale
	function automatic logic [7:0] max3(input logic [7:0] a,
		input logic [7:0] b, input logic [7:0] c);
		logic [7:0] m;
		m = (a > b) ? a : b;
		max3 = (m > c) ? m : c;
	endfunction : max3
	// Wide difference keeps full-scale swings from wrapping
	function automatic logic [15:0] lowpass(input logic [15:0] y,
		input logic [15:0] x, input logic [15:0] k);
		logic [16:0] d;
		logic [33:0] p;
		d = 17'($signed(x)) - 17'($signed(y));
		p = 34'($signed(d)) * 34'($signed({1'b0, k}));
		lowpass = y + p[31:16];
	endfunction : lowpass

	// ==============================
	// Blend targets
	logic [7:0] tgtRssi;
	logic [7:0] tgtSnr;
	logic [7:0] tgtMpath;
	logic [7:0] monoTarget;
	logic [7:0] attackRate;
	logic [7:0] releaseRate;
	metric_blend uRssi (.metric(qualityIn.rssi), .cfg(rssiCfg),
		.monoAmount(tgtRssi));
	metric_blend uSnr (.metric(qualityIn.snr), .cfg(snrCfg),
		.monoAmount(tgtSnr));
	metric_blend uMpath (.metric(qualityIn.multipath), .cfg(mpathCfg),
		.monoAmount(tgtMpath));
	always_comb begin
		monoTarget = max3(tgtRssi, tgtSnr, tgtMpath);
		attackRate = rssiCfg.attack;
		releaseRate = rssiCfg.relRate;
		if (monoTarget == tgtSnr) begin
			attackRate = snrCfg.attack;
			releaseRate = snrCfg.relRate;
		end
		if (monoTarget == tgtMpath) begin
			attackRate = mpathCfg.attack;
			releaseRate = mpathCfg.relRate;
		end
	end

	// ==============================
	// Pipeline state
	proc_state_t state_q;
	logic [15:0] sum_q;
	logic [15:0] diff_q;
	logic [7:0] blend_q;
	logic [7:0] softMute_q;
	stereo_t matrix_q;
	stereo_t deemph_q;
	logic [15:0] deemphK;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: state_q <= sampleValid ? ST_MATRIX : ST_IDLE;
				ST_MATRIX: state_q <= ST_FILTER;
				ST_FILTER: state_q <= ST_OUTPUT;
				ST_OUTPUT: state_q <= ST_IDLE;
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Capture: demodulate difference with pilot, weight by stereo amount
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sum_q <= 16'h0000;
			diff_q <= 16'h0000;
		end else if (state_q == ST_IDLE && sampleValid) begin
			sum_q <= sumIn;
			diff_q <= scale(scale(diffMpxIn, pilotRef[15:8]) <<< 1,
				`BLEND_FULL - blend_q);
		end
	end

	// Blend and soft mute move by rate steps once per sample
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			blend_q <= `BLEND_FULL;
			softMute_q <= `BLEND_ZERO;
		end else if (state_q == ST_OUTPUT) begin
			blend_q <= step_toward(blend_q, monoTarget, attackRate,
				releaseRate);
			softMute_q <= step_toward(softMute_q,
				(qualityIn.snr < softMuteThr) ? softMuteMax : `BLEND_ZERO,
				softMuteAttack, softMuteDecay);
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			matrix_q <= '0;
		end else if (state_q == ST_MATRIX) begin
			matrix_q.left <= sum_q + diff_q;
			matrix_q.right <= sum_q - diff_q;
		end
	end

	// One-pole low pass: y += k * (x - y)
	always_comb begin
		deemphK = (deemph_time_const_setting == `DEEMPH_SEL_75US) ?
			`DEEMPH_K_75 : `DEEMPH_K_50;
	end
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			deemph_q <= '0;
		end else if (state_q == ST_FILTER) begin
			deemph_q.left <= lowpass(deemph_q.left, matrix_q.left,
				deemphK);
			deemph_q.right <= lowpass(deemph_q.right, matrix_q.right,
				deemphK);
		end
	end

	// ==============================
	// Output gain and mute
	logic [7:0] gain;
	always_comb begin
		gain = 8'((16'(volume) * 16'(`BLEND_FULL - softMute_q)) >> 8);
	end
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			audioOut <= '0;
			left_analog_out <= 16'h0000;
			right_analog_out <= 16'h0000;
			audioValid <= 1'b0;
		end else begin
			audioValid <= (state_q == ST_OUTPUT);
			if (state_q == ST_OUTPUT) begin
				if (muteReq) begin
					audioOut <= '0;
					left_analog_out <= 16'h0000;
					right_analog_out <= 16'h0000;
				end else begin
					audioOut.left <= scale(deemph_q.left, gain);
					audioOut.right <= scale(deemph_q.right, gain);
					left_analog_out <= scale(deemph_q.left, gain);
					right_analog_out <= scale(deemph_q.right, gain);
				end
			end
		end
	end

	// ==============================
	// Status
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			statusValid <= 1'b0;
			blendStatus <= `BLEND_FULL;
			stereoStatus <= 1'b0;
			qualityStatus <= '0;
			softMuteStatus <= `BLEND_ZERO;
		end else begin
			statusValid <= signal_quality_status_cmd;
			if (signal_quality_status_cmd) begin
				blendStatus <= blend_q;
				stereoStatus <= (blend_q != `BLEND_FULL);
				qualityStatus <= qualityIn;
				softMuteStatus <= softMute_q;
			end
		end
	end
endmodule : fm_stereo_blend_audio_dsp

/* File: testbench/fm_blend_props.sv */
// Port-level assertions of the FM blend back end
`timescale 1ns/100ps
module fm_blend_props
	import fm_blend_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic sampleValid,
	input wire logic muteReq,
	input wire logic signal_quality_status_cmd,
	input wire quality_t qualityIn,
	input wire stereo_t audioOut,
	input wire logic [15:0] left_analog_out,
	input wire logic [15:0] right_analog_out,
	input wire logic audioValid,
	input wire logic statusValid,
	input wire logic [7:0] blendStatus,
	input wire logic stereoStatus,
	input wire quality_t qualityStatus
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// ==============================
	// Status and audio timing
	sequence s_cmd; signal_quality_status_cmd; endsequence
	sequence s_muted; muteReq [*5]; endsequence
	property p_stat; s_cmd |=> statusValid; endproperty
	a_stat: assert property (p_stat) else $error("no status");
	property p_cause;
		statusValid |-> $past(signal_quality_status_cmd);
	endproperty
	a_cause: assert property (p_cause) else $error("stray status");
	property p_snap; s_cmd |=> qualityStatus == $past(qualityIn); endproperty
	a_snap: assert property (p_snap) else $error("bad snapshot");
	property p_flag; statusValid |-> stereoStatus == (blendStatus != 8'hff);
	endproperty
	a_flag: assert property (p_flag) else $error("bad flag");
	property p_lat; audioValid |-> $past(sampleValid, 4); endproperty
	a_lat: assert property (p_lat) else $error("bad latency");
	property p_mute; s_muted ##0 audioValid |->
		left_analog_out == 16'h0 && right_analog_out == 16'h0; endproperty
	a_mute: assert property (p_mute) else $error("not muted");
	property p_pair; left_analog_out == audioOut.left &&
		right_analog_out == audioOut.right; endproperty
	a_pair: assert property (p_pair) else $error("pair differs");
	property p_hold; $changed(left_analog_out) |-> audioValid; endproperty
	a_hold: assert property (p_hold) else $error("output moved");
endmodule : fm_blend_props
bind fm_stereo_blend_audio_dsp fm_blend_props i_props (.*);

/* File: testbench/fm_host_model.sv */
// Host model issuing status polls and noting the answer
`timescale 1ns/100ps
module fm_host_model (
	input wire logic ref_clk,
	input wire logic poll,
	input wire logic statusValid,
	output logic signal_quality_status_cmd,
	output logic seen
);
	logic cmd_q;
	assign signal_quality_status_cmd = cmd_q === 1'h1;
	always_ff @(posedge ref_clk) begin
		cmd_q <= poll;
		seen <= statusValid;
	end
endmodule : fm_host_model

/* File: testbench/tb_fm_stereo_blend_audio_dsp.sv */
// Self-checking bench of the FM blend back end
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
$display("Error %s exp %h got %h", n, e, g); end end
module tb_fm_stereo_blend_audio_dsp
	import fm_blend_pkg::*;
;
	logic ref_clk = 1'h0, reset_n = 1'h0, sampleValid = 1'h0;
	logic muteReq = 1'h0, poll = 1'h0, seen, audioValid, statusValid;
	logic [15:0] sumIn = 16'h0, diffMpxIn = 16'h0, pilotRef = 16'h7fff, a, b;
	quality_t qualityIn = 24'h0, qualityStatus;
	blend_cfg_t cfg = 32'hc0_40_ff_ff;
	wire blend_cfg_t rssiCfg = cfg, snrCfg = cfg, mpathCfg = cfg;
	logic [1:0] deemph_time_const_setting = 2'h1;
	logic [7:0] volume = 8'hff, softMuteThr = 8'h0, softMuteMax = 8'h40;
	logic [7:0] softMuteAttack = 8'h8, softMuteDecay = 8'h8;
	logic [7:0] blendStatus, softMuteStatus;
	logic signal_quality_status_cmd, stereoStatus;
	logic [15:0] left_analog_out, right_analog_out;
	stereo_t audioOut;
	int bad_count = 0, n_tests = 0, i;
	always #5 ref_clk = ~ref_clk;
	fm_stereo_blend_audio_dsp i_dut (.*);
	fm_host_model i_host (.*);
	task automatic summarize(int late);
		bad_count += late;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : summarize
	function automatic logic [7:0] exp_mono(logic [7:0] m, blend_cfg_t c);
		int span;
		span = int'(c.stereoThr) - int'(c.monoThr);
		if (m < c.monoThr || span <= 0) return 8'hff;
		if (m >= c.stereoThr) return 8'h00;
		return 8'((255 * (int'(c.stereoThr) - int'(m))) / span);
	endfunction : exp_mono
	task automatic run(int n, logic [15:0] s, logic [15:0] d);
		int k;
		repeat (n) begin
			@(posedge ref_clk) #1 sampleValid = 1'h1;
			sumIn = s;
			diffMpxIn = d;
			@(posedge ref_clk) #1 sampleValid = 1'h0;
			k = 0;
			while (audioValid !== 1'h1 && k++ < 8) @(posedge ref_clk) #1;
			if (audioValid !== 1'h1) summarize(1);
		end
	endtask : run
	task automatic stat();
		@(posedge ref_clk) #1 poll = 1'h1;
		@(posedge ref_clk) #1 poll = 1'h0;
		repeat (2) @(posedge ref_clk);
		#1 `CHK("answer", 1'h1, seen)
	endtask : stat
	// ==============================
	// Test sequence
	initial begin
		void'($urandom(32'h660f));
		repeat (5) @(posedge ref_clk);
		#1 reset_n = 1'h1;
		`CHK("reset", 8'hff, blendStatus)
		for (i = 0; i < 3; i++) begin
			run(1, 16'($urandom), 16'($urandom));
			`CHK("mono", left_analog_out, right_analog_out)
		end
		qualityIn = {8'hc1 + 8'($urandom % 62), 16'hc1ff};
		run(4, 16'h0, 16'h4000);
		stat();
		`CHK("stereo", 8'h0, blendStatus)
		`CHK("flag", 1'h1, stereoStatus)
		`CHK("quality", qualityIn, qualityStatus)
		`CHK("sides", 2'h1, {left_analog_out[15], right_analog_out[15]})
		a = left_analog_out;
		pilotRef = 16'h0;
		run(1, 16'h0, 16'h4000);
		`CHK("pilot", 1'h1, $signed(left_analog_out) < $signed(a))
		pilotRef = 16'h7fff;
		for (i = 0; i < 3; i++) begin
			qualityIn = '1;
			qualityIn[8 * i +: 8] = 8'($urandom % 64);
			run(1, 16'h0, 16'h4000);
			stat();
			`CHK("any mono", 8'hff, blendStatus)
			qualityIn = '1;
			run(1, 16'h0, 16'h0);
		end
		cfg = 32'hc0_40_03_04;
		qualityIn = 24'h0;
		run(90, 16'h0, 16'h0);
		qualityIn = 24'h808080;
		run(1, 16'h0, 16'h0);
		stat();
		`CHK("release", 8'hfb, blendStatus)
		run(40, 16'h0, 16'h0);
		stat();
		`CHK("mid exact", exp_mono(8'h80, cfg), blendStatus)
		a = {8'h0, blendStatus};
		`CHK("mid", 1'h1, a > 16'h70 && a < 16'h90)
		qualityIn = 24'h0;
		run(1, 16'h0, 16'h0);
		stat();
		`CHK("attack", a[7:0] + 8'h3, blendStatus)
		$display("blend test done");
		for (i = 1; i < 3; i++) begin
			deemph_time_const_setting = 2'(i);
			run(300, 16'h0, 16'h0);
			run(1, 16'h4000, 16'h0);
			b = a;
			a = left_analog_out;
		end
		`CHK("deemph", 1'h1, $signed(b) > $signed(a) && $signed(a) > 0)
		run(300, 16'h4000, 16'h0);
		a = left_analog_out;
		volume = 8'h80;
		run(3, 16'h4000, 16'h0);
		`CHK("volume", 1'h1, $signed(left_analog_out) < $signed(a))
		$display("audio test done");
		softMuteThr = 8'h80;
		qualityIn = 24'hff20ff;
		run(3, 16'h0, 16'h0);
		stat();
		`CHK("soft on", 8'h18, softMuteStatus)
		run(9, 16'h0, 16'h0);
		stat();
		`CHK("soft max", 8'h40, softMuteStatus)
		qualityIn = '1;
		run(8, 16'h0, 16'h0);
		stat();
		`CHK("soft off", 8'h0, softMuteStatus)
		muteReq = 1'h1;
		run(1, 16'h4000, 16'h0);
		`CHK("mute", 16'h0, left_analog_out)
		$display("mute test done");
		summarize(0);
	end
endmodule : tb_fm_stereo_blend_audio_dsp
